//--- verilog/scc_ctrl.sv
// spread modulator, state clock divider, output format and pin control
// assumes divider ticks are one-cycle pulses synchronous to clock
`timescale 1ns/10ps
module scc_ctrl
    import scc_pkg::*;
(
    input wire logic clock, // 100 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic fractional_divider_zero_tick, // divider zero output pulse
    input wire logic fractional_divider_one_tick, // divider one output pulse
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [7:0] reg_addr, // register index
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data
    output logic reg_rvalid, // read data valid pulse
    input wire logic format_or_address_pin, // format strap pin
    input wire logic ref_in, // multi pin input level
    output logic ref_out, // multi pin drive level
    output logic ref_oe, // multi pin drive enable
    output logic sm_clk_en, // state machine clock enable
    output logic signed [31:0] fractional_divider_zero_num_offset, // numerator offset
    output logic out0_spread, // output zero carries spread
    output logic out1_spread, // output one carries spread
    output scc_out_t out0_cfg, // output zero format settings
    output scc_out_t out1_cfg, // output one format settings
    output logic otp_mode // strap captured high
);

    scc_state_t q, d;

    // ***********************************************
    // format helpers
    // ***********************************************
    function automatic scc_fmt_t eff_fmt(input logic [2:0] field,
                                         input logic from_pin,
                                         input logic pin);
        if (from_pin) begin
            eff_fmt = pin ? FMT_HCSL_85 : FMT_HCSL_100;
        end else begin
            eff_fmt = scc_fmt_t'(field);
        end
    endfunction

    function automatic scc_out_t decode(input scc_fmt_t f,
                                        input scc_fmt_t other,
                                        input logic [1:0] er);
        decode.fmt = f;
        decode.edge_rate = er;
        decode.slew_used = (f <= FMT_LVDS_DC);
        decode.p_on = (f != FMT_CMOS_N);
        decode.n_on = (f != FMT_CMOS_P);
        decode.n_antiphase = (f != FMT_CMOS_SAME);
        decode.invert = (f != other) && (f == FMT_LVDS_DC ||
            f == FMT_CMOS_ANTI || f == FMT_CMOS_SAME);
    endfunction

    logic sm_src, ref_src, spr_ok, center;
    logic [12:0] steps;
    logic [15:0] size;
    logic [13:0] leg;
    logic [2:0] ref_half;
    logic [7:0] div_limit;
    logic from_pin;
    scc_fmt_t f0, f1;

    always_comb begin
        d = q;
        d.sm_tick = 1'b0;
        d.rvalid = 1'b0;
        // ***********************************************
        // start-up strap, caught once after reset
        // ***********************************************
        if (!q.mode_valid) begin
            d.mode_valid = 1'b1;
            d.otp_mode = ref_in;
        end
        // ***********************************************
        // register access, unmapped reads return zero
        // ***********************************************
        if (reg_wr) begin
            if (reg_addr == REG_DIV0) begin
                d.r0 = reg_wdata;
            end else if (reg_addr == REG_ROUTE) begin
                d.r3 = reg_wdata;
            end else if (reg_addr == REG_SPREAD) begin
                d.r4 = {1'b0, reg_wdata[14:0]};
            end else if (reg_addr == REG_STEP) begin
                d.r5 = reg_wdata;
            end else if (reg_addr == REG_OUT0) begin
                d.r6 = reg_wdata;
            end else if (reg_addr == REG_OUT1) begin
                d.r7 = reg_wdata;
            end else if (reg_addr == REG_PRESET) begin
                d.r9 = {1'b0, reg_wdata[14:0]};
            end
        end
        if (reg_rd) begin
            d.rvalid = 1'b1;
            if (reg_addr == REG_DIV0) begin
                d.rdata = q.r0;
            end else if (reg_addr == REG_ROUTE) begin
                d.rdata = q.r3;
            end else if (reg_addr == REG_SPREAD) begin
                d.rdata = {q.ss != SS_IDLE, q.r4[14:0]};
            end else if (reg_addr == REG_STEP) begin
                d.rdata = q.r5;
            end else if (reg_addr == REG_OUT0) begin
                d.rdata = q.r6;
            end else if (reg_addr == REG_OUT1) begin
                d.rdata = q.r7;
            end else if (reg_addr == REG_PRESET) begin
                d.rdata = {q.otp_mode, q.r9[14:0]};
            end else begin
                d.rdata = 16'h0000;
            end
        end
        // ***********************************************
        // state machine clock divider
        // ***********************************************
        sm_src = q.r3[CH0_SEL_BIT] ? fractional_divider_one_tick : fractional_divider_zero_tick;
        div_limit = {1'b0, q.r0[DIV_LSB +: 7]} + DIV_OFFSET - 8'h01;
        if (sm_src) begin
            if (q.div_cnt >= div_limit) begin
                d.div_cnt = 8'h00;
                d.sm_tick = 1'b1;
            end else begin
                d.div_cnt = q.div_cnt + 8'h01;
            end
        end
        if (q.mode_valid && q.sm_tick) begin
            d.ready = 1'b1;
        end
        // ***********************************************
        // reference clock divider, 2/4/8
        // ***********************************************
        ref_src = q.r3[REF_SRC_BIT] ? fractional_divider_one_tick : fractional_divider_zero_tick;
        case (q.r9[REF_DIV_LSB +: 2])
            2'h0: ref_half = 3'h0;
            2'h1: ref_half = 3'h1;
            default: ref_half = 3'h3;
        endcase
        if (ref_src) begin
            if (q.ref_cnt >= ref_half) begin
                d.ref_cnt = 3'h0;
                d.ref_clk = ~q.ref_clk;
            end else begin
                d.ref_cnt = q.ref_cnt + 3'h1;
            end
        end
        // ***********************************************
        // multi pin function, released after strap
        // ***********************************************
        d.pin_out = 1'b0;
        d.pin_oe = 1'b0;
        if (q.mode_valid) begin
            case (scc_pin_t'(q.r7[PIN_FUNC_LSB +: 2]))
                PIN_LOW: d.pin_oe = 1'b1;
                PIN_FLOAT: d.pin_oe = 1'b0;
                PIN_REFCLK: begin
                    d.pin_oe = 1'b1;
                    d.pin_out = q.ref_clk;
                end
                default: begin
                    d.pin_oe = 1'b1;
                    d.pin_out = q.ready;
                end
            endcase
        end
        // ***********************************************
        // output formats
        // ***********************************************
        from_pin = q.otp_mode && q.r9[FMT_SRC_BIT];
        f0 = eff_fmt(q.r6[OUTPUT_ZERO_FORMAT_LSB +: 3], from_pin, format_or_address_pin);
        f1 = eff_fmt(q.r7[OUTPUT_ONE_FORMAT_LSB +: 3], from_pin, format_or_address_pin);
        d.out0 = decode(f0, f1, q.r6[OUT0_EDGE_LSB +: 2]);
        d.out1 = decode(f1, f0, q.r7[OUT1_EDGE_LSB +: 2]);
        // ***********************************************
        // spread modulator on divider zero
        // ***********************************************
        center = q.r4[SPR_TYPE_BIT];
        spr_ok = 1'b1;
        case (q.r9[PRESET_LSB +: 3])
            3'h0: begin
                steps = q.r4[SPR_STEPS_LSB +: 13];
                size = q.r5;
            end
            3'h1: begin
                steps = PRESET_STEPS;
                size = PRESET_SIZE_1;
            end
            3'h2: begin
                steps = PRESET_STEPS;
                size = PRESET_SIZE_2;
            end
            3'h3: begin
                steps = PRESET_STEPS;
                size = PRESET_SIZE_3;
            end
            3'h4: begin
                steps = PRESET_STEPS;
                size = PRESET_SIZE_4;
            end
            default: begin
                // reserved codes leave the divider unmodulated
                steps = 13'h0000;
                size = 16'h0000;
                spr_ok = 1'b0;
            end
        endcase
        // centre legs after the first span twice the depth, around zero
        leg = (center && !q.ss_first) ? {steps, 1'b0} : {1'b0, steps};
        if (!q.r4[SPR_EN_BIT] || !spr_ok || steps == 13'h0000) begin
            d.ss = SS_IDLE;
            d.offset = 32'sh0;
            d.ss_cnt = 14'h0000;
        end else begin
            case (q.ss)
                SS_IDLE: begin
                    d.ss = SS_UP;
                    d.ss_cnt = 14'h0000;
                    d.ss_first = 1'b1;
                    d.offset = 32'sh0;
                end
                SS_UP: begin
                    if (fractional_divider_zero_tick) begin
                        d.offset = q.offset + 32'(size);
                        d.ss_cnt = q.ss_cnt + 14'h0001;
                        if (q.ss_cnt + 14'h0001 >= leg) begin
                            d.ss = SS_DOWN;
                            d.ss_cnt = 14'h0000;
                            d.ss_first = 1'b0;
                        end
                    end
                end
                SS_DOWN: begin
                    if (fractional_divider_zero_tick) begin
                        d.offset = q.offset - 32'(size);
                        d.ss_cnt = q.ss_cnt + 14'h0001;
                        if (q.ss_cnt + 14'h0001 >= leg) begin
                            d.ss = SS_UP;
                            d.ss_cnt = 14'h0000;
                        end
                    end
                end
                default: d.ss = SS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            q <= '0;
            q.r0 <= RST_DIV0;
            q.r3 <= RST_ROUTE;
            q.r4 <= RST_SPREAD;
            q.r5 <= RST_STEP;
            q.r6 <= RST_OUT0;
            q.r7 <= RST_OUT1;
            q.r9 <= RST_PRESET;
            q.ss <= SS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign reg_rvalid = q.rvalid;
    assign ref_out = q.pin_out;
    assign ref_oe = q.pin_oe;
    assign sm_clk_en = q.sm_tick;
    assign fractional_divider_zero_num_offset = q.offset;
    // divider one has no modulator, so only divider zero sources spread
    assign out0_spread = q.r4[SPR_EN_BIT] && !q.r3[CH0_SEL_BIT];
    assign out1_spread = q.r4[SPR_EN_BIT] && !q.r3[CH1_SEL_BIT];
    assign out0_cfg = q.out0;
    assign out1_cfg = q.out1;
    assign otp_mode = q.otp_mode;

    // ***********************************************
    // checks
    // ***********************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic [8:0] h_ticks;
    logic h_ok;
    // a source tick in the pulse cycle already belongs to the next window
    always_ff @(posedge clock) begin
        if (reset) begin
            h_ticks <= 9'h000;
        end else if (sm_clk_en) begin
            h_ticks <= {8'h00, sm_src};
        end else if (sm_src) begin
            h_ticks <= h_ticks + 9'h001;
        end
    end
    // a window only counts when divide and source stayed put throughout
    always_ff @(posedge clock) begin
        if (reset || d.r0 != q.r0 || d.r3 != q.r3) begin
            h_ok <= 1'b0;
        end else if (sm_clk_en) begin
            h_ok <= 1'b1;
        end
    end

    property p_sm_src;
        sm_clk_en |-> $past(sm_src);
    endproperty
    a_sm_src: assert property (p_sm_src) else $error("tick w/o src");
    property p_sm_div;
        sm_clk_en && h_ok |->
            h_ticks == 9'({1'b0, q.r0[DIV_LSB +: 7]}) + 9'h002;
    endproperty
    a_sm_div: assert property (p_sm_div) else $error("bad divide");
    property p_off_clear;
        !q.r4[SPR_EN_BIT] |=> fractional_divider_zero_num_offset == 32'sh0;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("spread off");
    property p_down_pos;
        q.r4[SPR_EN_BIT] && !q.r4[SPR_TYPE_BIT] && $stable(q.r4) |->
            fractional_divider_zero_num_offset >= 32'sh0;
    endproperty
    a_down_pos: assert property (p_down_pos) else $error("down < 0");
    property p_step_up;
        q.ss == SS_UP && fractional_divider_zero_tick && q.r4[SPR_EN_BIT] && spr_ok &&
            steps != 13'h0000 |=> fractional_divider_zero_num_offset == $past(q.offset) +
            32'($past(size));
    endproperty
    a_step_up: assert property (p_step_up) else $error("step");
    property p_reserved;
        q.r9[PRESET_LSB +: 3] > 3'h4 |=> q.ss == SS_IDLE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("rsvd");
    property p_fmt_p;
        $past(f0) == FMT_CMOS_P |-> out0_cfg.p_on && !out0_cfg.n_on;
    endproperty
    a_fmt_p: assert property (p_fmt_p) else $error("fmt P only");
    property p_invert;
        ##1 out0_cfg.invert |-> out0_cfg.fmt != out1_cfg.fmt &&
            out0_cfg.fmt >= FMT_LVDS_DC && out0_cfg.fmt != FMT_CMOS_P &&
            out0_cfg.fmt != FMT_CMOS_N;
    endproperty
    a_invert: assert property (p_invert) else $error("invert");
    property p_pin_fmt;
        from_pin && format_or_address_pin |=> out0_cfg.fmt == FMT_HCSL_85;
    endproperty
    a_pin_fmt: assert property (p_pin_fmt) else $error("pin fmt");
    property p_strap;
        $rose(q.mode_valid) |-> otp_mode == $past(ref_in);
    endproperty
    a_strap: assert property (p_strap) else $error("strap");
    property p_float;
        q.mode_valid && q.r7[PIN_FUNC_LSB +: 2] == 2'h1 |=> !ref_oe;
    endproperty
    a_float: assert property (p_float) else $error("float");

    c_spread: cover property (q.ss == SS_UP ##[1:50] q.ss == SS_DOWN);
    c_refclk: cover property (ref_oe && $rose(ref_out));
    c_invert: cover property (out1_cfg.invert);
    c_sm: cover property (sm_clk_en ##[1:20] sm_clk_en);

endmodule

//--- inc/scc_pkg.sv
// constants, field layout and types of the spread and output config block
// assumes one 100 MHz clock; divider outputs arrive as one-cycle ticks
//
// How it works
// - state clock source follows channel-zero divider select
// - state clock divides by field value plus two
// - spread enable modulates divider zero outputs only
// - type bit: zero down-spread, one centre-spread
// - preset select: custom, four down depths, reserved
// - custom step size applied over step count
// - three-bit format field decodes eight output styles
// - mixed formats: DC LVDS, CMOS pairs inverted
// - fuse mode: format pin picks HCSL termination
// - two-bit edge-rate field, LVDS and HCSL only
// - start-up strap: low register mode, high fuse
// - reference clock: selected divider over 2/4/8
// - pin function: low, float, clock, ready
package scc_pkg;

    // ***********************************************
    // register offsets
    // ***********************************************
    localparam logic [7:0] REG_DIV0 = 8'h00;
    localparam logic [7:0] REG_ROUTE = 8'h03;
    localparam logic [7:0] REG_SPREAD = 8'h04;
    localparam logic [7:0] REG_STEP = 8'h05;
    localparam logic [7:0] REG_OUT0 = 8'h06;
    localparam logic [7:0] REG_OUT1 = 8'h07;
    localparam logic [7:0] REG_PRESET = 8'h09;

    // ***********************************************
    // field positions
    // ***********************************************
    localparam int DIV_LSB = 3;
    localparam int CH1_SEL_BIT = 0;
    localparam int REF_SRC_BIT = 1;
    localparam int CH0_SEL_BIT = 4;
    localparam int SPR_EN_BIT = 0;
    localparam int SPR_TYPE_BIT = 1;
    localparam int SPR_STEPS_LSB = 2;
    localparam int SPR_ACTIVE_BIT = 15;
    localparam int OUTPUT_ZERO_FORMAT_LSB = 0;
    localparam int OUT0_EDGE_LSB = 3;
    localparam int OUTPUT_ONE_FORMAT_LSB = 2;
    localparam int OUT1_EDGE_LSB = 5;
    localparam int PIN_FUNC_LSB = 13;
    localparam int REF_DIV_LSB = 0;
    localparam int FMT_SRC_BIT = 8;
    localparam int PRESET_LSB = 9;
    localparam int MODE_BIT = 15;

    // ***********************************************
    // reset values and counts
    // ***********************************************
    localparam logic [15:0] RST_DIV0 = 16'h0000;
    localparam logic [15:0] RST_ROUTE = 16'h0000;
    localparam logic [15:0] RST_SPREAD = 16'h0000;
    localparam logic [15:0] RST_STEP = 16'h0000;
    localparam logic [15:0] RST_OUT0 = 16'h0000;
    localparam logic [15:0] RST_OUT1 = 16'h6000;
    localparam logic [15:0] RST_PRESET = 16'h0000;
    localparam logic [7:0] DIV_OFFSET = 8'h02;
    localparam logic [12:0] PRESET_STEPS = 13'h0C66;
    localparam logic [15:0] PRESET_SIZE_1 = 16'h0010;
    localparam logic [15:0] PRESET_SIZE_2 = 16'h0028;
    localparam logic [15:0] PRESET_SIZE_3 = 16'h0030;
    localparam logic [15:0] PRESET_SIZE_4 = 16'h0050;

    // ***********************************************
    // types
    // ***********************************************
    typedef enum logic [2:0] {
        FMT_HCSL_100 = 3'h0, FMT_HCSL_85 = 3'h1, FMT_LVDS_AC = 3'h2,
        FMT_LVDS_DC = 3'h3, FMT_CMOS_P = 3'h4, FMT_CMOS_N = 3'h5,
        FMT_CMOS_ANTI = 3'h6, FMT_CMOS_SAME = 3'h7
    } scc_fmt_t;

    typedef enum logic [1:0] {
        PIN_LOW = 2'h0, PIN_FLOAT = 2'h1, PIN_REFCLK = 2'h2, PIN_READY = 2'h3
    } scc_pin_t;

    typedef enum logic [2:0] {
        SS_IDLE = 3'b001, SS_UP = 3'b010, SS_DOWN = 3'b100
    } scc_ss_t;

    typedef struct packed {
        scc_fmt_t fmt;
        logic [1:0] edge_rate;
        logic slew_used;
        logic p_on;
        logic n_on;
        logic n_antiphase;
        logic invert;
    } scc_out_t;

    typedef struct packed {
        logic [15:0] r0, r3, r4, r5, r6, r7, r9;
        logic [15:0] rdata;
        logic rvalid;
        logic mode_valid;
        logic otp_mode;
        logic ready;
        logic [7:0] div_cnt;
        logic sm_tick;
        logic [2:0] ref_cnt;
        logic ref_clk;
        logic pin_out;
        logic pin_oe;
        scc_ss_t ss;
        logic [13:0] ss_cnt;
        logic ss_first;
        logic signed [31:0] offset;
        scc_out_t out0, out1;
    } scc_state_t;

endpackage

//--- dv/tb.sv
// self-checking bench for the spread and output config block
// assumes divider ticks modelled here as simple periodic pulses
`timescale 1ns/10ps
module tb import scc_pkg::*;;
    logic clock = 1'h0, reset = 1'h1, ref_in = 1'h1, strap_lvl = 1'h0;
    logic fractional_divider_zero_tick = 1'h0, fractional_divider_one_tick = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_q;
    logic reg_rvalid, ref_out, ref_oe, sm_clk_en, otp_mode;
    logic out0_spread, out1_spread;
    logic signed [31:0] fractional_divider_zero_num_offset, mx, mn;
    scc_out_t out0_cfg, out1_cfg;
    logic [31:0] seed = 32'hF1356328;
    int errors = 0, checks = 0, p0 = 0, p1 = 0, cyc = 0, bad, n, k, s;
    logic [7:0] ra [7] = '{REG_DIV0, REG_ROUTE, REG_SPREAD, REG_STEP,
        REG_OUT0, REG_OUT1, REG_PRESET};
    logic [15:0] rv [7] = '{RST_DIV0, RST_ROUTE, RST_SPREAD, RST_STEP,
        RST_OUT0, RST_OUT1, RST_PRESET};
    int psz [5] = '{0, PRESET_SIZE_1, PRESET_SIZE_2, PRESET_SIZE_3,
        PRESET_SIZE_4};

    scc_ctrl DUT (.clock(clock), .reset(reset), .fractional_divider_zero_tick(fractional_divider_zero_tick),
        .fractional_divider_one_tick(fractional_divider_one_tick), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .format_or_address_pin(strap_lvl),
        .ref_in(ref_in), .ref_out(ref_out), .ref_oe(ref_oe),
        .sm_clk_en(sm_clk_en), .fractional_divider_zero_num_offset(fractional_divider_zero_num_offset),
        .out0_spread(out0_spread), .out1_spread(out1_spread),
        .out0_cfg(out0_cfg), .out1_cfg(out1_cfg), .otp_mode(otp_mode));

    // ****************
    // helpers
    // ****************
    always #5 clock = ~clock;

    // period 0 keeps a divider silent
    always @(posedge clock) begin
        cyc <= cyc + 1;
        fractional_divider_zero_tick <= p0 != 0 && cyc % p0 == 0;
        fractional_divider_one_tick <= p1 != 0 && cyc % p1 == 0;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'h0;
        @(negedge clock);
        chk("rvalid", 32'h1, reg_rvalid);
        rd_q = reg_rdata;
    endtask

    // cycles between rising edges; second call skips a stale interval
    task automatic gap(bit which);
        int first;
        logic prev, cur;
        first = -1;
        n = -1;
        prev = 1'h1;
        for (int i = 0; i < 1000 && n < 0; i++) begin
            @(negedge clock);
            cur = which ? ref_out : sm_clk_en;
            if (cur === 1'h1 && prev !== 1'h1) begin
                if (first < 0) first = i;
                else n = i - first;
            end
            prev = cur;
        end
    endtask

    task automatic per(bit which, int e, string nm);
        gap(which);
        gap(which);
        chk(nm, e, n);
    endtask

    task automatic sweep(int cnt, int size);
        logic signed [31:0] last, d;
        @(negedge clock);
        last = fractional_divider_zero_num_offset;
        mx = last;
        mn = last;
        bad = 0;
        repeat (cnt) begin
            @(negedge clock);
            d = fractional_divider_zero_num_offset - last;
            if ((d == 0 || d == size || d == -size) !== 1'h1) bad++;
            if (fractional_divider_zero_num_offset > mx) mx = fractional_divider_zero_num_offset;
            if (fractional_divider_zero_num_offset < mn) mn = fractional_divider_zero_num_offset;
            last = fractional_divider_zero_num_offset;
        end
    endtask

    // lane fields only matter for single-ended codes
    task automatic ocheck(string nm, scc_out_t g, int f, int o, int er);
        scc_out_t e;
        logic [9:0] m;
        e.fmt = scc_fmt_t'(f[2:0]);
        e.edge_rate = er[1:0];
        e.slew_used = f < 4;
        e.p_on = f != 5;
        e.n_on = f != 4;
        e.n_antiphase = f != 7;
        e.invert = f != o && (f == 3 || f >= 6);
        m = {3'h7, f < 4 ? 2'h3 : 2'h0, 1'h1, {3{f > 3}}, 1'h1};
        chk(nm, e & m, g & m);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'h0;
        repeat (2) @(negedge clock);
        chk("otp_mode", 32'h1, otp_mode);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk("reset value", i == 6 ? rv[i] | 16'h8000 : rv[i], rd_q);
        end
        for (int i = 0; i < 7; i++) begin
            s = rnd() & (i == 2 ? 32'hFFFE : 32'hFFFF);
            wr(ra[i], s[15:0]);
            rd(ra[i]);
            k = i == 6 ? 32'h8000 : 0;
            chk("readback", k | s[14:0] | (i == 2 || i == 6 ? 0 : s[15:0]),
                rd_q);
        end
        wr(8'h02, 16'hBEEF);
        rd(8'h02);
        chk("unmapped", 32'h0, rd_q);
        $display("done: register access");
        for (int t = 0; t < 3; t++) begin
            k = t == 0 ? 127 : rnd() % 8;
            wr(REG_DIV0, k << 3);
            wr(REG_ROUTE, 16'h0000);
            p0 = 1;
            p1 = 3;
            per(0, k + 2, "state clock fractional_divider_zero");
            wr(REG_ROUTE, 16'h0010);
            p1 = 2;
            per(0, 2 * (k + 2), "state clock fractional_divider_one");
        end
        $display("done: state clock");
        for (int f = 0; f < 4; f++) begin
            if (f == 2) continue;
            wr(REG_OUT1, f << 13);
            repeat (2) @(negedge clock);
            chk("pin enable", f != 1, ref_oe);
            if (f != 1) chk("pin level", f == 3, ref_out);
        end
        for (int src = 0; src < 2; src++) begin
            for (int c = 0; c < 3; c++) begin
                p0 = src ? 0 : 1;
                p1 = src ? 1 : 0;
                wr(REG_ROUTE, src << 1);
                wr(REG_PRESET, c);
                wr(REG_OUT1, 16'h4000);
                per(1, 2 << c, "ref clock period");
            end
        end
        $display("done: multi pin");
        p0 = 1;
        wr(REG_PRESET, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            wr(REG_ROUTE, (m & 2) << 3 | (m & 1));
            wr(REG_SPREAD, 16'h0010 | m[2]);
            @(negedge clock);
            chk("out0_spread", m[2] & ~m[1], out0_spread);
            chk("out1_spread", m[2] & ~m[0], out1_spread);
        end
        wr(REG_ROUTE, 16'h0000);
        for (int t = 0; t < 4; t++) begin
            k = rnd() % 8 + 2;
            s = rnd() % 200 + 1;
            wr(REG_SPREAD, 16'h0000);
            wr(REG_STEP, s);
            wr(REG_SPREAD, k << 2 | t[0] << 1 | 1);
            sweep(8 * k, s);
            chk("step size", 32'h0, bad);
            chk("peak", k * s, mx);
            chk("trough", t[0] ? -k * s : 0, mn);
            rd(REG_SPREAD);
            chk("active", 16'h8000 | k << 2 | t[0] << 1 | 1, rd_q);
        end
        for (int c = 1; c < 8; c++) begin
            wr(REG_SPREAD, 16'h0000);
            repeat (2) @(negedge clock);
            chk("offset idle", 32'h0, fractional_divider_zero_num_offset);
            wr(REG_PRESET, c << 9);
            wr(REG_SPREAD, 16'h0011);
            sweep(40, c < 5 ? psz[c] : 0);
            chk("preset steps", 32'h0, bad);
            chk("preset trough", 32'h0, mn);
            chk("preset rising", c < 5, mx > 0);
        end
        wr(REG_SPREAD, 16'h0000);
        wr(REG_PRESET, 16'h0000);
        $display("done: spread");
        for (int a = 0; a < 8; a++) begin
            for (int b = 0; b < 8; b++) begin
                k = rnd() % 4;
                s = rnd() % 4;
                wr(REG_OUT0, k << 3 | a);
                wr(REG_OUT1, 16'h6000 | s << 5 | b << 2);
                repeat (2) @(negedge clock);
                ocheck("out0_cfg", out0_cfg, a, b, k);
                ocheck("out1_cfg", out1_cfg, b, a, s);
            end
        end
        wr(REG_OUT0, 16'h0003);
        wr(REG_OUT1, 16'h601C);
        wr(REG_PRESET, 16'h0100);
        for (int v = 0; v < 2; v++) begin
            strap_lvl <= v[0];
            repeat (3) @(negedge clock);
            chk("pin fmt 0", v, out0_cfg.fmt);
            chk("pin fmt 1", v, out1_cfg.fmt);
        end
        $display("done: formats");
        @(posedge clock);
        reset <= 1'h1;
        ref_in <= 1'h0;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        repeat (2) @(negedge clock);
        chk("otp_mode low", 32'h0, otp_mode);
        rd(REG_PRESET);
        chk("status low", 32'h0, rd_q);
        wr(REG_OUT0, 16'h0003);
        wr(REG_PRESET, 16'h0100);
        repeat (2) @(negedge clock);
        chk("register fmt", 32'h3, out0_cfg.fmt);
        $display("done: start-up strap");
        conclude();
    end

    initial begin
        repeat (50000) @(posedge clock);
        errors++;
        conclude();
    end
endmodule
